// ==== logic/pecl_top.v ====
// peripheral enable register with unlock key, on the configuration bus port
`timescale 1ns/1ps
`default_nettype none
`include "pecl_map.vh"

module pecl_top (
   // clock and reset
   input wire clock,
   input wire nrst,
   // configuration bus port
   input wire cfg_req,
   input wire cfg_wr,
   input wire [31:0] cfg_addr,
   input wire [31:0] cfg_wdata,
   output reg cfg_ack,
   output reg [31:0] cfg_rdata,
   // peripheral enables and power-down
   output reg second_video_port_enable,
   output reg second_video_port_pd,
   output reg first_video_port_enable,
   output reg first_video_port_pd,
   output reg two_wire_controller_enable,
   output reg two_wire_controller_pd,
   output reg buffered_serial_port_enable,
   output reg buffered_serial_port_pd,
   output reg unsupported_serial_port_enable,
   // shared pin steering
   output reg audio_port_pin_select,
   output reg video_upper_pins_on,
   output reg [1:0] video_lower_pin_sel,
   // lock state
   output reg config_locked_flag
);

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function in_block;
      input [31:0] addr;
      begin
         in_block = (addr & `PECL_BLOCK_MASK) == `PECL_BLOCK_BASE;
      end
   endfunction

   wire hit = cfg_req & in_block(cfg_addr); // R1 R2
   wire [11:0] ofs = cfg_addr[11:0];
   wire sel_enable = hit & (ofs == `PECL_OFS_ENABLE); // R1
   wire sel_lock = hit & (ofs == `PECL_OFS_LOCK); // R16
   wire wr_enable = sel_enable & cfg_wr;
   wire wr_lock = sel_lock & cfg_wr;

   // ----------------------------------------
   // register state
   // ----------------------------------------
   reg [6:0] enable_q;
   reg [6:0] enable_d;
   reg lock_d;

   always @* begin
      enable_d = enable_q;
      // only writable bits move, and only while unlocked
      if (wr_enable && !config_locked_flag) begin // R13 R17
         enable_d = (cfg_wdata[6:0] & `PECL_WRITABLE_MASK) |
                    (enable_q & ~`PECL_WRITABLE_MASK); // R3
      end
   end

   always @* begin
      lock_d = config_locked_flag;
      if (wr_enable) begin
         lock_d = 1'b1; // R18
      end else if (wr_lock) begin
         // a wrong key locks again rather than leaving the door open
         lock_d = (cfg_wdata != `PECL_UNLOCK_KEY); // R11 R16
      end
   end

   wire pin_audio_d;
   wire pin_upper_d;
   wire [1:0] pin_lower_d;

   pecl_pin_select u_pin_select (
      .enable_value(enable_d),
      .audio_port_pin_select(pin_audio_d),
      .video_upper_pins_on(pin_upper_d),
      .video_lower_pin_sel(pin_lower_d)
   );

   // ----------------------------------------
   // state and outputs
   // ----------------------------------------
   // outputs are loaded from the next value, so they move with the register itself
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         enable_q <= `PECL_ENABLE_RESET; // R7 R8
         config_locked_flag <= `PECL_LOCK_RESET; // R17
         second_video_port_enable <= 1'b0;
         second_video_port_pd <= 1'b1;
         first_video_port_enable <= 1'b0;
         first_video_port_pd <= 1'b1;
         two_wire_controller_enable <= 1'b0;
         two_wire_controller_pd <= 1'b1;
         buffered_serial_port_enable <= 1'b1;
         buffered_serial_port_pd <= 1'b0;
         unsupported_serial_port_enable <= 1'b1;
         audio_port_pin_select <= 1'b0;
         video_upper_pins_on <= 1'b1;
         video_lower_pin_sel <= `PECL_LOWER_SERIAL;
      end else begin
         enable_q <= enable_d;
         config_locked_flag <= lock_d;
         second_video_port_enable <= enable_d[`PECL_BIT_VIDEO2_EN]; // R4 R20
         second_video_port_pd <= ~enable_d[`PECL_BIT_VIDEO2_EN]; // R4
         first_video_port_enable <= enable_d[`PECL_BIT_VIDEO1_EN]; // R5 R20
         first_video_port_pd <= ~enable_d[`PECL_BIT_VIDEO1_EN]; // R5
         two_wire_controller_enable <= enable_d[`PECL_BIT_TWO_WIRE_EN]; // R6 R20
         two_wire_controller_pd <= ~enable_d[`PECL_BIT_TWO_WIRE_EN]; // R6
         buffered_serial_port_enable <= enable_d[`PECL_BIT_SERIAL_EN]; // R8 R20
         buffered_serial_port_pd <= ~enable_d[`PECL_BIT_SERIAL_EN]; // R8
         // drives the unsupported_serial_port_enable output and also steers the video lower pins to the serial setting
         unsupported_serial_port_enable <= enable_d[`PECL_BIT_UNSUP_EN]; // R7
         audio_port_pin_select <= pin_audio_d; // R9 R20
         video_upper_pins_on <= pin_upper_d; // R9
         video_lower_pin_sel <= pin_lower_d; // R10
      end
   end

   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   // reads show the state before any write in the same request
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cfg_ack <= 1'b0;
         cfg_rdata <= 32'h00000000;
      end else begin
         cfg_ack <= hit;
         if (hit && !cfg_wr && sel_enable) begin
            cfg_rdata <= {25'h0, enable_q}; // R3 R17
         end else if (hit && !cfg_wr && sel_lock) begin
            cfg_rdata <= {31'h0, config_locked_flag}; // R12 R16
         end else begin
            cfg_rdata <= 32'h00000000;
         end
      end
   end

endmodule
`default_nettype wire

// ==== logic/pecl_map.vh ====
// address map, field positions and reset values of the peripheral enable block
// Notes on behaviour
// (R1) Registers decode inside the 4K block at 0x01b3f000; enable register sits at the base.
// (R2) Registers are reached only through the configuration bus port.
// (R3) Enable register bits 31:7 and 4 read zero; writes there are ignored.
// (R4) Bit 6 enables the second video port; zero at reset keeps it off and powered down.
// (R5) Bit 5 enables the first video port; zero at reset keeps it off and powered down.
// (R6) Bit 3 enables the two-wire controller; zero at reset keeps it off and powered down.
// (R7) Bit 2 resets to one; software must clear it; it drives no peripheral. Here it drives unsupported_serial_port_enable.
// (R8) Bit 1 enables the buffered serial port, one at reset; zero powers it down.
// (R9) Bit 0 high gives shared pins to the audio port, low to video upper data.
// (R10) Video lower data pins follow bits 2 and 5, whatever bit 0 holds.
// (R11) Writing exactly 0x10c0010c to the lock register unlocks the enable register.
// (R12) Lock register read returns one while locked, zero while unlocked.
// (R13) Enable bits change only while unlocked; locked writes have no effect.
// (R14) Software should not reassign shared pins at run time.
// (R15) Software should stop peripheral traffic before clearing its enable.
// (R16) Lock register sits at 0x01b3f018; status in bit 0, key written as 32 bits.
// (R17) Lock status resets to locked; locked writes keep contents, reads unaffected.
// (R18) Any write to the enable register relocks it.
// (R19) Masters wait 128 processor cycles after enabling before touching the peripheral.
// (R20) Enable, power-down and pin selects follow register state with no extra delay.
`ifndef PECL_MAP_VH
`define PECL_MAP_VH

`define PECL_BLOCK_BASE 32'h01b3f000
`define PECL_BLOCK_MASK 32'hfffff000
`define PECL_OFS_ENABLE 12'h000
`define PECL_OFS_LOCK 12'h018
`define PECL_UNLOCK_KEY 32'h10c0010c

`define PECL_BIT_AUDIO_SEL 0
`define PECL_BIT_SERIAL_EN 1
`define PECL_BIT_UNSUP_EN 2
`define PECL_BIT_TWO_WIRE_EN 3
`define PECL_BIT_VIDEO1_EN 5
`define PECL_BIT_VIDEO2_EN 6

`define PECL_WRITABLE_MASK 7'h6f
`define PECL_ENABLE_RESET 7'h06
`define PECL_LOCK_RESET 1'b1

`define PECL_LOWER_IDLE 2'h0
`define PECL_LOWER_VIDEO 2'h1
`define PECL_LOWER_SERIAL 2'h2

`define PECL_SETTLE_CYCLES 128

`endif

// ==== logic/pecl_pin_select.v ====
// shared pin steering decoded from the enable register value
`timescale 1ns/1ps
`default_nettype none
`include "pecl_map.vh"

module pecl_pin_select (
   // register value
   input wire [6:0] enable_value,
   // pin steering
   output wire audio_port_pin_select,
   output wire video_upper_pins_on,
   output reg [1:0] video_lower_pin_sel
);

   assign audio_port_pin_select = enable_value[`PECL_BIT_AUDIO_SEL]; // R9
   assign video_upper_pins_on = ~enable_value[`PECL_BIT_AUDIO_SEL]; // R9

   // unsupported serial port takes priority over the video port
   always @* begin
      if (enable_value[`PECL_BIT_UNSUP_EN]) begin // R10
         video_lower_pin_sel = `PECL_LOWER_SERIAL;
      end else if (enable_value[`PECL_BIT_VIDEO1_EN]) begin // R10
         video_lower_pin_sel = `PECL_LOWER_VIDEO;
      end else begin
         video_lower_pin_sel = `PECL_LOWER_IDLE;
      end
   end

endmodule
`default_nettype wire

// ==== verif/pecl_top_asserts.sv ====
// port assertions for the peripheral enable block
`timescale 1ns/1ps
`default_nettype none
module pecl_chk (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // bus and state
   input wire logic cfg_req,
   input wire logic cfg_wr,
   input wire logic [31:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   input wire logic cfg_ack,
   input wire logic [31:0] cfg_rdata,
   input wire logic first_video_port_enable,
   input wire logic audio_port_pin_select,
   input wire logic video_upper_pins_on,
   input wire logic config_locked_flag
);
   wire inb = cfg_req && cfg_addr[31:12] == 20'h01b3f;
   wire wen = inb && cfg_wr && cfg_addr[11:0] == 12'h000;
   wire wlk = inb && cfg_wr && cfg_addr[11:0] == 12'h018;
   wire rlk = inb && !cfg_wr && cfg_addr[11:0] == 12'h018;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   a_ack_inblock: assert property (inb |=> cfg_ack) else $error("ack missing");
   a_no_stray: assert property (!inb |=> !cfg_ack) else $error("stray ack");
   a_reserved_zero: assert property (inb && !cfg_wr && cfg_addr[11:0] == 12'h000 |=>
      cfg_rdata[31:7] == 25'h0 && !cfg_rdata[4]) else $error("reserved bits");
   a_key_unlock: assert property (wlk && cfg_wdata == 32'h10c0010c |=> !config_locked_flag)
      else $error("key ignored");
   a_write_relock: assert property (wen |=> config_locked_flag) else $error("no relock");
   a_locked_hold: assert property (wen && config_locked_flag |=>
      $stable(first_video_port_enable) && $stable(audio_port_pin_select)) else $error("locked change");
   a_open_write: assert property (wen && !config_locked_flag |=>
      first_video_port_enable == $past(cfg_wdata[5]) && audio_port_pin_select == $past(cfg_wdata[0]))
      else $error("write lost");
   a_lock_read: assert property (rlk |=> cfg_rdata == {31'h0, $past(config_locked_flag)})
      else $error("lock read");
   a_pin_split: assert property (video_upper_pins_on != audio_port_pin_select) else $error("pins");
   c_open_write: cover property (wen && !config_locked_flag);
   c_locked_write: cover property (wen && config_locked_flag);
   c_lock_read: cover property (rlk);
endmodule
bind pecl_top pecl_chk u_chk (.*);
`default_nettype wire

// ==== verif/peripheral_enable_config_lock_tb.sv ====
// self-checking bench for the peripheral enable block
`timescale 1ns/1ps
`default_nettype none
module peripheral_enable_config_lock_tb;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic cfg_req = 1'b0;
   logic cfg_wr = 1'b0;
   logic [31:0] cfg_addr = 32'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic [31:0] r;
   logic [6:0] m = 7'h06;
   logic lk = 1'b1;
   int err_total = 0;
   int checked = 0;
   wire cfg_ack, second_video_port_enable, second_video_port_pd, first_video_port_enable, first_video_port_pd;
   wire two_wire_controller_enable, two_wire_controller_pd, buffered_serial_port_enable, buffered_serial_port_pd;
   wire unsupported_serial_port_enable, audio_port_pin_select, video_upper_pins_on, config_locked_flag;
   wire [1:0] video_lower_pin_sel;
   wire [31:0] cfg_rdata;
   wire [31:0] outs = {18'h0, second_video_port_enable, second_video_port_pd, first_video_port_enable,
      first_video_port_pd, two_wire_controller_enable, two_wire_controller_pd, buffered_serial_port_enable,
      buffered_serial_port_pd, unsupported_serial_port_enable, audio_port_pin_select, video_upper_pins_on,
      video_lower_pin_sel, config_locked_flag};
   always #12.5 clock = ~clock;
   pecl_top u_pecl_top (.*);
   function logic [31:0] xo(input logic [6:0] v, input logic l);
      xo = {18'h0, v[6], !v[6], v[5], !v[5], v[3], !v[3], v[1], !v[1], v[2], v[0], !v[0],
         v[2] ? 2'h2 : {1'b0, v[5]}, l};
   endfunction
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task close_out;
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one access per cycle; request left up so accesses run back to back
   task acc(input logic w, input logic [31:0] a, input logic [31:0] d);
      logic inb;
      logic [31:0] e;
      inb = a[31:12] == 20'h01b3f;
      e = a[11:0] == 12'h000 ? {25'h0, m} : a[11:0] == 12'h018 ? {31'h0, lk} : 32'h0;
      cfg_req = 1'b1;
      cfg_wr = w;
      cfg_addr = a;
      cfg_wdata = d;
      @(negedge clock);
      chk(32'(cfg_ack), 32'(inb));
      if (inb && !w) chk(cfg_rdata, e);
      if (inb && w && a[11:0] == 12'h000) begin
         if (!lk) m = d[6:0] & 7'h6f;
         lk = 1'b1;
      end else if (inb && w && a[11:0] == 12'h018) lk = d !== 32'h10c0010c;
      chk(outs, xo(m, lk));
   endtask
   initial begin
      #25000;
      err_total++;
      close_out;
   end
   initial begin
      r = $urandom(32'h37a4e40c);
      repeat (6) @(negedge clock);
      chk(outs, xo(7'h06, 1'b1));
      nrst = 1'b1;
      acc(1'b1, 32'h01b3f000, 32'hffffffff);
      acc(1'b1, 32'h01b3f018, 32'h10c0010d);
      acc(1'b1, 32'h01b3f018, 32'h10c0010c);
      acc(1'b0, 32'h01b3f018, 32'h0);
      acc(1'b1, 32'h01b3f000, 32'hffffffff);
      acc(1'b0, 32'h01b3f000, 32'h0);
      // software flow: unlock, enable with the unsupported bit cleared, read back, settle
      acc(1'b1, 32'h01b3f018, 32'h10c0010c);
      acc(1'b1, 32'h01b3f000, 32'h0000006b);
      acc(1'b0, 32'h01b3f000, 32'h0);
      cfg_req = 1'b0;
      repeat (128) @(negedge clock);
      chk(32'(cfg_ack), 32'h0);
      chk(outs, xo(m, lk));
      // bus idle before enables drop; pin select kept where it was
      acc(1'b1, 32'h01b3f018, 32'h10c0010c);
      acc(1'b1, 32'h01b3f000, 32'h00000001);
      for (int i = 0; i < 300; i++) begin
         r = $urandom;
         // reset in mid-run must drop every setting back and relock
         if (i == 150) begin
            cfg_req = 1'b0;
            nrst = 1'b0;
            @(negedge clock);
            chk(outs, xo(7'h06, 1'b1));
            chk(32'(cfg_ack), 32'h0);
            chk(cfg_rdata, 32'h0);
            m = 7'h06;
            lk = 1'b1;
            nrst = 1'b1;
         end
         case (r[1:0])
            2'h0: acc(1'b1, 32'h01b3f018, r[2] ? 32'h10c0010c : $urandom);
            2'h1: acc(1'b1, 32'h01b3f000, $urandom);
            2'h2: acc(1'b0, r[3] ? 32'h01b3f000 : 32'h01b3f018, $urandom);
            default: acc(r[4], r[5] ? 32'h01b3f004 : 32'h01b40000, $urandom);
         endcase
      end
      cfg_req = 1'b0;
      close_out;
   end
endmodule
`default_nettype wire
